// ### rtl/smc_pkg.sv
// Shared constants and types for the secure memory card command logic.
package smc_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ_MAIN = 8'h30;
  localparam logic [7:0] CMD_UPD_MAIN = 8'h38;
  localparam logic [7:0] CMD_READ_PROT = 8'h34;
  localparam logic [7:0] CMD_PROTECT = 8'h3C;
  localparam logic [7:0] CMD_READ_SEC = 8'h31;
  localparam logic [7:0] CMD_UPD_SEC = 8'h39;
  localparam logic [7:0] CMD_COMPARE = 8'h33;
  // ==========================================================
  // Counts, in card clock pulses unless stated
  localparam logic [4:0] CMD_BITS = 5'h18;
  localparam logic [8:0] PROC_BOTH_CLKS = 9'h0FF;
  localparam logic [8:0] PROC_ONE_CLKS = 9'h07C;
  localparam logic [8:0] PROC_NONE_CLKS = 9'h001;
  localparam logic [8:0] CMP_CLKS = 9'h002;
  localparam logic [8:0] FAIL_CLKS = 9'h008;
  localparam logic [8:0] MAIN_BYTES = 9'h100;
  localparam logic [8:0] PROT_BYTES = 9'h004;
  localparam logic [8:0] SEC_BYTES = 9'h004;
  localparam logic [8:0] ATR_BYTES = 9'h004;
  localparam int OUT_FIFO_DEPTH = 4;
  localparam int BYTE_W = 8;
  // ==========================================================
  // Address limits and values after reset
  localparam logic [7:0] PROT_LIMIT = 8'h20;
  localparam logic [7:0] SEC_CODE_LAST = 8'h03;
  localparam logic [2:0] EC_RESET = 3'h7;
  localparam logic [31:0] PROT_RESET = 32'hFFFF_FFFF;
  localparam logic [7:0] MAIN_ERASED = 8'hFF;
  // ==========================================================
  // Answer-to-reset header fields
  localparam logic [3:0] PROTO_TWO_WIRE = 4'hA;
  localparam logic [1:0] STRUCT_ONE = 2'h2;
  localparam logic READ_TO_END = 1'b0;
  localparam logic READ_DEF_LEN = 1'b1;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {SMC_RESET, SMC_IDLE, SMC_CMD, SMC_OUT, SMC_PROC} smc_mode_type;
  typedef enum logic [1:0] {SRC_MAIN, SRC_PROT, SRC_SEC} smc_src_type;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
    logic [7:0] ctrl;
  } smc_cmd_type;
endpackage

// ### rtl/smc_card.sv
// Command interpreter of a two-wire secure memory card, with its output byte FIFO.
`timescale 1ns/1ps

// ==========================================================
// Output byte FIFO
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  input logic flush,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap naturally, so DEPTH must be a power of two.
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_p_r, rd_p_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_p_r];
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_p_r] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_p_r <= '0;
      rd_p_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wr_p_r <= '0;
      rd_p_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_p_r <= wr_p_r + AW'(push);
      rd_p_r <= rd_p_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // smc_fifo

module smc_card #(
  parameter logic [23:0] CODE_RESET = 24'hFFFFFF,
  parameter logic READ_MODE = smc_pkg::READ_TO_END,
  parameter logic [7:0] HDR_H3 = 8'h00,
  parameter logic [7:0] HDR_H4 = 8'h00
) (
  // Clock and reset
  input logic sys_clk,
  input logic rst_n,
  // Card contacts
  input logic card_clk,
  input logic card_rst,
  input logic io_in,
  output logic io_out,
  output logic io_oe
);
  import smc_pkg::*;
  logic rst_s1_r, rst_i_n;
  logic clk_q_r, rst_q_r, io_q_r;
  logic clk_rise, clk_fall, rst_fall, enter_rst, start_ev, stop_ev, exec;
  smc_mode_type mode_r;
  smc_cmd_type rx_r;
  logic [4:0] bit_cnt_r;
  logic [8:0] proc_cnt_r;
  logic [7:0] mem_r [0:255];
  logic [31:0] prot_r;
  logic [2:0] ec_r;
  logic [7:0] code_r [0:2];
  logic unlocked_r, armed_r, alter_ok_r;
  logic [1:0] step_r;
  smc_src_type src_kind_r;
  logic [7:0] src_idx_r, src_byte;
  logic [8:0] src_left_r;
  logic f_in_ready, f_valid, push, pop, ser_step, ser_done;
  logic [7:0] f_data, sh_r;
  logic [2:0] bit_r;
  logic have_r, io_oe_r, io_out_r;
  logic d_out, wr_main, wr_ec, wr_code, wr_prot, arm, cmp_ok, cmp_bad, read_seen;
  smc_src_type d_kind;
  logic [7:0] d_idx, main_rd, code_sel;
  logic [8:0] d_left, d_cnt;
  logic [2:0] ec_val, ec_diff;
  logic in_prot, ec_zero, wr_ok, one_clear;

  // Erase when any bit must rise, write when any bit must fall.
  function automatic logic [8:0] proc_clks(input logic [7:0] old_v, input logic [7:0] new_v);
    logic er, wr;
    er = |(new_v & ~old_v);
    wr = |(old_v & ~new_v);
    if (er && wr) return PROC_BOTH_CLKS;
    else if (er || wr) return PROC_ONE_CLKS;
    else return PROC_NONE_CLKS;
  endfunction

  // ==========================================================
  // Reset release and pin sampling
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_i_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_i_n <= rst_s1_r;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      clk_q_r <= 1'b0;
      rst_q_r <= 1'b0;
      io_q_r <= 1'b1;
    end else begin
      clk_q_r <= card_clk;
      rst_q_r <= card_rst;
      io_q_r <= io_in;
    end
  end
  assign clk_rise = card_clk & ~clk_q_r;
  assign clk_fall = ~card_clk & clk_q_r;
  assign rst_fall = ~card_rst & rst_q_r;
  assign enter_rst = card_rst & (mode_r != SMC_RESET);
  assign start_ev = clk_q_r & card_clk & io_q_r & ~io_in;
  assign stop_ev = clk_q_r & card_clk & ~io_q_r & io_in;
  assign exec = stop_ev & (mode_r == SMC_CMD);

  // ==========================================================
  // Command decode
  assign main_rd = mem_r[rx_r.addr];
  assign code_sel = code_r[rx_r.addr[1:0] - 2'h1];
  assign in_prot = rx_r.addr < PROT_LIMIT;
  assign ec_zero = ec_r == 3'h0;
  assign wr_ok = unlocked_r & alter_ok_r & ~ec_zero;
  assign ec_diff = ec_r & ~rx_r.data[2:0];
  assign one_clear = (ec_diff != 3'h0) && ((ec_diff & (ec_diff - 3'h1)) == 3'h0)
    && (rx_r.data[7:3] == 5'h00) && ((rx_r.data[2:0] & ~ec_r) == 3'h0);
  always_comb begin
    d_out = 1'b0;
    d_kind = SRC_MAIN;
    d_idx = rx_r.addr;
    d_left = 9'h000;
    d_cnt = FAIL_CLKS;
    wr_main = 1'b0;
    wr_ec = 1'b0;
    wr_code = 1'b0;
    wr_prot = 1'b0;
    ec_val = rx_r.data[2:0];
    arm = 1'b0;
    cmp_ok = 1'b0;
    cmp_bad = 1'b0;
    read_seen = 1'b0;
    // The clock rise that carries the stop mark is counted as one more pulse.
    if (bit_cnt_r == CMD_BITS + 5'h01) begin
      case (rx_r.ctrl)
        CMD_READ_MAIN: begin
          d_out = 1'b1;
          d_left = MAIN_BYTES - {1'b0, rx_r.addr};
          read_seen = 1'b1;
        end
        CMD_READ_PROT: begin
          d_out = 1'b1;
          d_kind = SRC_PROT;
          d_idx = 8'h00;
          d_left = PROT_BYTES;
          read_seen = 1'b1;
        end
        CMD_READ_SEC: begin
          d_out = 1'b1;
          d_kind = SRC_SEC;
          d_idx = 8'h00;
          d_left = SEC_BYTES;
          read_seen = 1'b1;
        end
        CMD_UPD_MAIN: begin
          if (wr_ok && !(in_prot && !prot_r[rx_r.addr[4:0]])) begin
            wr_main = 1'b1;
            d_cnt = proc_clks(main_rd, rx_r.data);
          end
        end
        CMD_UPD_SEC: begin
          if (rx_r.addr == 8'h00 && wr_ok) begin
            wr_ec = 1'b1;
            d_cnt = proc_clks({5'h00, ec_r}, {5'h00, rx_r.data[2:0]});
          end else if (rx_r.addr == 8'h00 && alter_ok_r && one_clear) begin
            wr_ec = 1'b1;
            ec_val = ec_r & rx_r.data[2:0];
            arm = 1'b1;
            d_cnt = proc_clks({5'h00, ec_r}, {5'h00, ec_val});
          end else if (rx_r.addr != 8'h00 && rx_r.addr <= SEC_CODE_LAST && wr_ok) begin
            wr_code = 1'b1;
            d_cnt = proc_clks(code_sel, rx_r.data);
          end
        end
        CMD_PROTECT: begin
          if (wr_ok && in_prot && prot_r[rx_r.addr[4:0]]) begin
            wr_prot = main_rd == rx_r.data;
            d_cnt = PROC_ONE_CLKS;
          end
        end
        CMD_COMPARE: begin
          if (!ec_zero && armed_r && rx_r.addr == {6'h00, step_r} + 8'h01) begin
            cmp_ok = rx_r.data == code_sel;
            cmp_bad = ~cmp_ok;
            d_cnt = cmp_ok ? CMP_CLKS : FAIL_CLKS;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Mode sequencing
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      mode_r <= SMC_IDLE;
      rx_r <= '0;
      bit_cnt_r <= 5'h00;
      proc_cnt_r <= 9'h000;
    end else if (enter_rst) begin
      mode_r <= SMC_RESET;
      proc_cnt_r <= 9'h000;
    end else begin
      case (mode_r)
        SMC_RESET: if (rst_fall) mode_r <= SMC_OUT;
        SMC_IDLE: begin
          if (start_ev) begin
            mode_r <= SMC_CMD;
            bit_cnt_r <= 5'h00;
          end
        end
        SMC_CMD: begin
          if (start_ev) begin
            bit_cnt_r <= 5'h00;
          end else if (stop_ev) begin
            mode_r <= d_out ? SMC_OUT : SMC_PROC;
            proc_cnt_r <= d_cnt;
          end else if (clk_rise) begin
            // Shifting stops at 24 bits so the stop pulse cannot push the control byte out.
            if (bit_cnt_r < CMD_BITS) rx_r <= {io_in, rx_r[23:1]};
            if (bit_cnt_r != 5'h1F) bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        SMC_OUT: if (ser_done) mode_r <= SMC_IDLE;
        SMC_PROC: begin
          if (clk_fall && proc_cnt_r == 9'h000) mode_r <= SMC_IDLE;
          else if (clk_fall) proc_cnt_r <= proc_cnt_r - 9'h001;
        end
        default: mode_r <= SMC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Memories
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      for (int i = 0; i < 256; i++) mem_r[i] <= MAIN_ERASED;
      mem_r[0] <= {PROTO_TWO_WIRE, 2'h0, STRUCT_ONE};
      mem_r[1] <= {READ_MODE, 7'h00};
      mem_r[2] <= HDR_H3;
      mem_r[3] <= HDR_H4;
      prot_r <= PROT_RESET;
    end else if (exec) begin
      if (wr_main) mem_r[rx_r.addr] <= rx_r.data;
      if (wr_prot) prot_r[rx_r.addr[4:0]] <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ec_r <= EC_RESET;
      code_r[0] <= CODE_RESET[7:0];
      code_r[1] <= CODE_RESET[15:8];
      code_r[2] <= CODE_RESET[23:16];
      unlocked_r <= 1'b0;
      armed_r <= 1'b0;
      step_r <= 2'h0;
      alter_ok_r <= 1'b0;
    end else begin
      if (mode_r == SMC_RESET && rst_fall) alter_ok_r <= 1'b1;
      if (exec) begin
        if (read_seen) alter_ok_r <= 1'b1;
        if (wr_ec) ec_r <= ec_val;
        if (wr_code) code_r[rx_r.addr[1:0] - 2'h1] <= rx_r.data;
        if (arm) armed_r <= 1'b1;
        if (arm || cmp_bad) step_r <= 2'h0;
        if (cmp_bad) armed_r <= 1'b0;
        if (cmp_ok) step_r <= step_r + 2'h1;
        if (cmp_ok && step_r == 2'h2) unlocked_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output byte source
  always_comb begin
    case (src_kind_r)
      SRC_PROT: src_byte = prot_r[{src_idx_r[1:0], 3'h0} +: 8];
      SRC_SEC: src_byte = (src_idx_r == 8'h00) ? {5'h00, ec_r}
        : (unlocked_r ? code_r[src_idx_r[1:0] - 2'h1] : 8'h00);
      default: src_byte = mem_r[src_idx_r];
    endcase
  end
  assign push = (src_left_r != 9'h000) & f_in_ready & ~enter_rst;
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      src_kind_r <= SRC_MAIN;
      src_idx_r <= 8'h00;
      src_left_r <= 9'h000;
    end else if (enter_rst) begin
      src_kind_r <= SRC_MAIN;
      src_idx_r <= 8'h00;
      src_left_r <= ATR_BYTES;
    end else if (exec && d_out) begin
      src_kind_r <= d_kind;
      src_idx_r <= d_idx;
      src_left_r <= d_left;
    end else if (push) begin
      src_idx_r <= src_idx_r + 8'h01;
      src_left_r <= src_left_r - 9'h001;
    end
  end
  // The card clock is far slower than sys_clk, so the FIFO is refilled long before it drains.
  smc_fifo #(.WIDTH(BYTE_W), .DEPTH(OUT_FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_i_n),
    .flush(enter_rst),
    .in_valid(src_left_r != 9'h000),
    .in_ready(f_in_ready),
    .in_data(src_byte),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // ==========================================================
  // Data line driver, open drain: enable high pulls the line low
  assign ser_step = (mode_r == SMC_OUT && clk_fall) || (mode_r == SMC_RESET && rst_fall);
  assign pop = ser_step & ~have_r & f_valid;
  assign ser_done = ser_step & ~have_r & ~f_valid & (src_left_r == 9'h000);
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      io_oe_r <= 1'b0;
      io_out_r <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      have_r <= 1'b0;
    end else if (enter_rst) begin
      io_oe_r <= 1'b0;
      have_r <= 1'b0;
    end else if (mode_r == SMC_PROC) begin
      if (clk_fall) io_oe_r <= proc_cnt_r != 9'h000;
    end else if (ser_step) begin
      if (have_r) begin
        io_oe_r <= ~sh_r[bit_r];
        bit_r <= bit_r + 3'h1;
        have_r <= bit_r != 3'h7;
      end else if (f_valid) begin
        io_oe_r <= ~f_data[0];
        sh_r <= f_data;
        bit_r <= 3'h1;
        have_r <= 1'b1;
      end else begin
        io_oe_r <= 1'b0;
      end
    end else if (mode_r != SMC_OUT) begin
      io_oe_r <= 1'b0;
    end
  end
  assign io_oe = io_oe_r;
  assign io_out = io_out_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_i_n);
  a_pin_edge: assert property ($changed(io_oe_r) |-> $past(clk_fall | rst_fall | enter_rst))
    else $error("Data line changed off a falling clock edge.");
  a_cmd_frame: assert property (mode_r == SMC_IDLE && start_ev && !card_rst
    |=> mode_r == SMC_CMD && bit_cnt_r == 5'h00)
    else $error("Start mark did not open a command.");
  a_code_hidden: assert property (push && src_kind_r == SRC_SEC && src_idx_r != 8'h00 && !unlocked_r |-> src_byte == 8'h00)
    else $error("Security code leaked before verification.");
  a_both_steps: assert property (exec && wr_main && (main_rd & ~rx_r.data) != 8'h00 && (rx_r.data & ~main_rd) != 8'h00 |=> mode_r == SMC_PROC && proc_cnt_r == 9'h0FF)
    else $error("Erase and write did not take 255 clocks.");
  a_write_only: assert property (exec && wr_main && rx_r.data != main_rd && (rx_r.data & ~main_rd) == 8'h00 |=> proc_cnt_r == 9'h07C)
    else $error("Write only did not take 124 clocks.");
  a_main_update: assert property (exec && wr_main |=> mem_r[$past(rx_r.addr)] == $past(rx_r.data))
    else $error("Main byte not updated.");
  a_prot_guard: assert property (exec && rx_r.ctrl == CMD_UPD_MAIN && in_prot && !prot_r[rx_r.addr[4:0]] |=> proc_cnt_r == 9'h008 ##1 mem_r[$past(rx_r.addr, 2)] == $past(main_rd, 2))
    else $error("Protected byte was written.");
  a_prot_match: assert property (exec && rx_r.ctrl == CMD_PROTECT && main_rd != rx_r.data |=> prot_r == $past(prot_r))
    else $error("Protection bit set on mismatch.");
  a_ec_no_raise: assert property (!unlocked_r |=> (ec_r & ~$past(ec_r)) == 3'h0)
    else $error("Error counter raised while locked.");
  a_unlock_hold: assert property (unlocked_r |=> unlocked_r [*8])
    else $error("Unlock was lost.");
  a_proc_low: assert property (mode_r == SMC_PROC && clk_fall && proc_cnt_r != 9'h000 |=> io_oe_r)
    else $error("Line not held low during processing.");
  a_empty_lock: assert property (exec && rx_r.ctrl == CMD_COMPARE && ec_zero && !unlocked_r |=> !unlocked_r && proc_cnt_r == 9'h008)
    else $error("Compare accepted with empty counter.");
  a_break: assert property (card_rst && !card_clk && mode_r != SMC_RESET |=> mode_r == SMC_RESET && !io_oe_r)
    else $error("Break did not abort and release.");
endmodule // smc_card

// ### dv/smc_rdr.sv
// Card reader model: makes the card clock and reset and pulls the shared data line.
`timescale 1ns/1ps

module smc_rdr #(
  parameter int HALF = 6
) (
  // System clock
  input wire logic sys_clk,
  // Card contacts
  input wire logic io_line,
  output logic card_clk,
  output logic card_rst,
  output logic pull_low
);
  logic got_q[$];

  initial begin
    card_clk = 1'b0;
    card_rst = 1'b0;
    pull_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // The clock stands still low between frames, so the card never sees stray edges.
  task automatic clk_to(input logic v);
    @(posedge sys_clk);
    card_clk <= v;
    hold(HALF);
  endtask

  task automatic line_to(input logic low);
    @(posedge sys_clk);
    pull_low <= low;
    hold(HALF);
  endtask

  task automatic send(input logic [23:0] c, input int nb);
    clk_to(1'b1);
    line_to(1'b1);
    clk_to(1'b0);
    for (int i = 0; i < nb; i++) begin
      line_to(~c[i]);
      clk_to(1'b1);
      clk_to(1'b0);
    end
    line_to(1'b1);
    clk_to(1'b1);
    line_to(1'b0);
  endtask

  task automatic pulses(input int lim, output int n);
    n = 0;
    clk_to(1'b0);
    while (io_line === 1'b0 && n < lim) begin
      n++;
      if (n < lim) begin
        clk_to(1'b1);
        clk_to(1'b0);
      end
    end
  endtask

  task automatic rd_bits(input int nb, output logic rel);
    got_q.delete();
    for (int i = 0; i < nb; i++) begin
      clk_to(1'b0);
      got_q.push_back(io_line);
      clk_to(1'b1);
    end
    clk_to(1'b0);
    rel = io_line;
  endtask

  // Reset is raised while the clock is low, which also serves as a break.
  task automatic atr(output logic brk, output logic rel);
    got_q.delete();
    @(posedge sys_clk);
    card_rst <= 1'b1;
    hold(HALF);
    brk = io_line;
    clk_to(1'b1);
    clk_to(1'b0);
    @(posedge sys_clk);
    card_rst <= 1'b0;
    hold(HALF);
    got_q.push_back(io_line);
    for (int i = 1; i < 32; i++) begin
      clk_to(1'b1);
      clk_to(1'b0);
      got_q.push_back(io_line);
    end
    clk_to(1'b1);
    clk_to(1'b0);
    rel = io_line;
  endtask
endmodule // smc_rdr

// ### dv/testbench.sv
// Self-checking bench: reader model, card, and a reference model of the card memories.
`timescale 1ns/1ps

module testbench;
  import smc_pkg::*;
  localparam logic [23:0] CODE = 24'h5A3CC3;
  logic sys_clk;
  logic rst_n;
  logic card_clk;
  logic card_rst;
  logic pull_low;
  logic io_out;
  logic io_oe;
  wire io_line;
  int err_count;
  int comparisons;
  int n;
  logic [31:0] rnd;
  logic [7:0] mm[256];
  logic pr[32];
  logic [7:0] code[4];
  logic [2:0] ec;
  logic unl;
  logic arm;
  logic ready;
  int idx;
  logic exp_q[$];

  // Open-drain line with pull-up: low while either party pulls.
  assign io_line = ~(io_oe | pull_low);

  smc_card #(.CODE_RESET(CODE), .READ_MODE(READ_DEF_LEN)) i_smc_card (
    .sys_clk(sys_clk), .rst_n(rst_n), .card_clk(card_clk), .card_rst(card_rst),
    .io_in(io_line), .io_out(io_out), .io_oe(io_oe));

  smc_rdr i_smc_rdr (.sys_clk(sys_clk), .io_line(io_line), .card_clk(card_clk),
    .card_rst(card_rst), .pull_low(pull_low));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking and reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // ==========================================================
  // Reference model
  function automatic int upd_n(input logic [7:0] o, input logic [7:0] d);
    logic er;
    logic wr;
    er = |(~o & d);
    wr = |(o & ~d);
    return (er && wr) ? 255 : ((er || wr) ? 124 : 1);
  endfunction

  task automatic reset_model();
    foreach (mm[i]) mm[i] = MAIN_ERASED;
    mm[0] = {PROTO_TWO_WIRE, 2'h0, STRUCT_ONE};
    mm[1] = {READ_DEF_LEN, 7'h00};
    mm[2] = 8'h00;
    mm[3] = 8'h00;
    foreach (pr[i]) pr[i] = 1'b1;
    for (int i = 1; i < 4; i++) code[i] = CODE[8*i-8 +: 8];
    ec = EC_RESET;
    unl = 1'b0;
    arm = 1'b0;
    ready = 1'b0;
    idx = 1;
  endtask

  task automatic push_b(input logic [7:0] b);
    for (int j = 0; j < 8; j++) exp_q.push_back(b[j]);
  endtask

  task automatic model(input smc_cmd_type c, input int nb, output int r);
    logic [7:0] old;
    logic ok;
    exp_q.delete();
    r = 8;
    old = mm[c.addr];
    ok = ready && unl && ec != 3'h0;
    if (nb == 24) begin
      case (c.ctrl)
        CMD_READ_MAIN: begin
          r = -1;
          for (int i = c.addr; i < 256; i++) push_b(mm[i]);
        end
        CMD_READ_PROT: begin
          r = -1;
          for (int i = 0; i < 32; i++) exp_q.push_back(pr[i]);
        end
        CMD_READ_SEC: begin
          r = -1;
          push_b({5'h00, ec});
          for (int i = 1; i < 4; i++) push_b(unl ? code[i] : 8'h00);
        end
        CMD_UPD_MAIN: if (ok && (c.addr > 8'h1F || pr[c.addr[4:0]])) begin
          r = upd_n(old, c.data);
          mm[c.addr] = c.data;
        end
        CMD_PROTECT: if (ok && c.addr < 8'h20 && pr[c.addr[4:0]]) begin
          r = 124;
          if (old == c.data) pr[c.addr[4:0]] = 1'b0;
        end
        CMD_UPD_SEC: if (ok && c.addr == 8'h00) begin
          r = upd_n({5'h00, ec}, {5'h00, c.data[2:0]});
          ec = c.data[2:0];
        end else if (ok && c.addr < 8'h04) begin
          r = upd_n(code[c.addr[1:0]], c.data);
          code[c.addr[1:0]] = c.data;
        end else if (ready && c.addr == 8'h00 && c.data[7:3] == 5'h00 &&
            (c.data[2:0] & ~ec) == 3'h0 && $countones(ec & ~c.data[2:0]) == 1) begin
          r = 124;
          ec = c.data[2:0];
          arm = 1'b1;
          idx = 1;
        end
        CMD_COMPARE: if (arm && ec != 3'h0 && c.addr == idx && c.data == code[idx%4]) begin
          r = 2;
          idx++;
          unl = unl | (idx == 4);
        end else begin
          arm = 1'b0;
        end
        default: ;
      endcase
      if (r < 0) ready = 1'b1;
    end
  endtask

  // ==========================================================
  // Transfers
  task automatic do_cmd(input smc_cmd_type c, input int nb);
    int got;
    logic rel;
    model(c, nb, got);
    i_smc_rdr.send(c, nb);
    if (got < 0) begin
      i_smc_rdr.rd_bits(exp_q.size(), rel);
      foreach (exp_q[i]) check(i_smc_rdr.got_q[i], exp_q[i]);
      check(rel, 1'b1);
    end else begin
      n = got;
      i_smc_rdr.pulses(400, got);
      check(got, n);
    end
  endtask

  task automatic do_atr();
    logic brk;
    logic rel;
    i_smc_rdr.atr(brk, rel);
    check(brk, 1'b1);
    for (int i = 0; i < 32; i++) check(i_smc_rdr.got_q[i], mm[i/8][i%8]);
    check(rel, 1'b1);
    ready = 1'b1;
  endtask

  task automatic power_up();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset_model();
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    err_count = 0;
    comparisons = 0;
    rnd = 32'h0CA33078;
    power_up();
    check(io_line, 1'b1);
    check(io_out, 1'b0);
    do_cmd({8'h55, 8'h40, CMD_UPD_MAIN}, 24);
    do_atr();
    do_cmd({16'h0000, CMD_READ_SEC}, 24);
    do_cmd({8'h11, 8'h01, CMD_UPD_SEC}, 24);
    do_cmd({8'h55, 8'h40, CMD_UPD_MAIN}, 24);
    do_cmd({8'h07, 8'h00, CMD_UPD_SEC}, 24);
    do_cmd({8'h06, 8'h00, CMD_UPD_SEC}, 24);
    for (int i = 1; i < 4; i++) do_cmd({code[i], 8'(i), CMD_COMPARE}, 24);
    do_cmd({8'hFF, 8'h00, CMD_UPD_SEC}, 24);
    do_cmd({8'hA5, 8'h02, CMD_UPD_SEC}, 24);
    do_cmd({16'h0000, CMD_READ_SEC}, 24);
    $display("test unlock done");
    do_cmd({8'h0F, 8'h28, CMD_UPD_MAIN}, 24);
    do_cmd({8'hF0, 8'h28, CMD_UPD_MAIN}, 24);
    do_cmd({8'hFF, 8'h28, CMD_UPD_MAIN}, 24);
    repeat (5) begin
      rnd = xs(rnd);
      do_cmd({rnd[15:8], rnd[7:0], CMD_UPD_MAIN}, 24);
      do_cmd({rnd[15:8], rnd[7:0], CMD_UPD_MAIN}, 24);
    end
    do_cmd({16'h00FA, CMD_READ_MAIN}, 24);
    $display("test update done");
    do_cmd({~mm[5], 8'h05, CMD_PROTECT}, 24);
    do_cmd({mm[5], 8'h05, CMD_PROTECT}, 24);
    do_cmd({8'h12, 8'h05, CMD_UPD_MAIN}, 24);
    do_cmd({mm[5], 8'h05, CMD_PROTECT}, 24);
    do_cmd({16'h0000, CMD_READ_PROT}, 24);
    do_cmd({8'h00, 8'h30, CMD_UPD_MAIN}, 23);
    $display("test protect done");
    model({8'h33, 8'h64, CMD_UPD_MAIN}, 24, n);
    i_smc_rdr.send({8'h33, 8'h64, CMD_UPD_MAIN}, 24);
    i_smc_rdr.pulses(10, n);
    check(n, 10);
    do_atr();
    $display("test break done");
    power_up();
    do_cmd({16'h0000, CMD_READ_SEC}, 24);
    repeat (3) begin
      do_cmd({5'h00, ec & (ec - 3'h1), 8'h00, CMD_UPD_SEC}, 24);
      do_cmd({~code[1], 8'h01, CMD_COMPARE}, 24);
    end
    do_cmd({8'h00, 8'h50, CMD_UPD_MAIN}, 24);
    do_cmd({16'h0000, CMD_READ_SEC}, 24);
    $display("test lockout done");
    end_of_test();
  end
endmodule // testbench
